// ==== rtl/acf_defines.svh ====
/*
 Opcodes, subcommands, record layout, power timing, host register map.
 Assumes inclusion by bare name from files that need the figures.
*/
`ifndef ACF_DEFINES_SVH
`define ACF_DEFINES_SVH

`define ACF_CLK_MHZ 25
`define ACF_PARTIAL_US 10
`define ACF_SLUMBER_MS 10
`define ACF_DEVSLP_EXIT_MS 20
`define ACF_IDLE_CYC 12'h0800
`define ACF_READ_THRESH 8'hC8

`define ACF_PM_NONE 2'h0
`define ACF_PM_SLUMBER 2'h2

`define ACF_OP_FUA_DMA 8'h3D
`define ACF_OP_FUA_MUL 8'hCE
`define ACF_OP_VFY 8'h40
`define ACF_OP_VFY_EXT 8'h42
`define ACF_OP_SMART 8'hB0
`define ACF_OP_UNLOCK 8'hF2
`define ACF_OPS_TRUST 8'h5C, 8'h5D, 8'h5E, 8'h5F
`define ACF_OPS_WR 8'h30, 8'h34, 8'hCA, 8'h35, 8'hC5, 8'h39, 8'h61
`define ACF_OPS_RD 8'h20, 8'h24, 8'hC8, 8'h25, 8'hC4, 8'h29, 8'h60
`define ACF_OPS_MISC 8'hE5, 8'h06, 8'h92, 8'h90, 8'hE7, 8'hEA, 8'hEC, 8'hE3, 8'hE1, \
   8'h91, 8'hE4, 8'h2F, 8'h47, 8'h10, 8'hF6, 8'hF3, 8'hF4, 8'hF5, 8'hF1, 8'h70, 8'hEF, \
   8'hC6, 8'hE6, 8'hE2, 8'hE0, 8'hE8, 8'h3F, 8'h57, 8'h45

`define ACF_SM_RDATA 8'hD0
`define ACF_SM_RTHR 8'hD1
`define ACF_SM_ASAVE 8'hD2
`define ACF_SM_OFFL 8'hD4
`define ACF_SM_RLOG 8'hD5
`define ACF_SM_WLOG 8'hD6
`define ACF_SM_EN 8'hD8
`define ACF_SM_DIS 8'hD9
`define ACF_SM_STAT 8'hDA

`define ACF_ATTR_NUM 3'h5
`define ACF_REC_LAST 4'hB
`define ACF_ID_INIT_BAD 8'hA5
`define ACF_ID_LATER_BAD 8'hA6
`define ACF_ID_MAX_ERASE 8'hA3
`define ACF_ID_AVG_ERASE 8'hA4
`define ACF_ID_PON_HOURS 8'h09
`define ACF_ID_PWR_CYC 8'h0C
`define ACF_ATTR_FLAGS 16'h0003
`define ACF_ATTR_VALUE 8'h64
`define ACF_ATTR_THR 8'h0A
`define ACF_SMART_OK 32'h0000_0001

`define ACF_REG_CMD 8'h00
`define ACF_REG_LBA 8'h04
`define ACF_REG_DATA 8'h08
`define ACF_REG_KEY 8'h0C
`define ACF_REG_PM 8'h10
`define ACF_REG_STAT 8'h14
`define ACF_REG_RDATA 8'h18
`define ACF_RESP_OK 2'h0
`define ACF_RESP_ERR 2'h2

`endif

// ==== rtl/acf_pkg.sv ====
/*
 Types for the ATA front end; only the power state type is shared by both ends.
 Assumes nothing.
*/
package acf_pkg;
   typedef enum logic [2:0] {ACF_ACTIVE, ACF_PARTIAL, ACF_SLUMBER, ACF_DEVSLP, ACF_WAKE} acf_pwr_t;
   typedef enum logic [2:0] {ACF_IDLE, ACF_EXEC, ACF_MEDIA, ACF_COMMIT, ACF_SMART} acf_cst_t;
   typedef enum logic [3:0] {ACF_C_BAD, ACF_C_MISC, ACF_C_UNLK, ACF_C_WR, ACF_C_FUA, ACF_C_RD,
      ACF_C_VFY, ACF_C_TRUST, ACF_C_SMART} acf_cls_t;
endpackage

// ==== rtl/acf_if.sv ====
/*
 Link between the host controller and the drive front end.
 Assumes both ends share aclk; devslp is a pin and is synchronised by the drive.
*/
`timescale 1ns/1ps
interface acf_if;
   import acf_pkg::*;
   logic cmd_we;
   logic [7:0] op;
   logic [7:0] feat;
   logic [15:0] lba;
   logic [31:0] wd;
   logic wpar;
   logic [31:0] key;
   logic rack;
   logic [1:0] pm_req;
   logic wake;
   logic devslp;
   logic busy;
   logic done;
   logic err;
   logic rdv;
   logic [31:0] rdd;
   acf_pwr_t pwr;
   logic dev_pm;
   modport dev (input cmd_we, op, feat, lba, wd, wpar, key, rack, pm_req, wake, devslp,
      output busy, done, err, rdv, rdd, pwr, dev_pm);
   modport host (output cmd_we, op, feat, lba, wd, wpar, key, rack, pm_req, wake, devslp,
      input busy, done, err, rdv, rdd, pwr, dev_pm);
endinterface

// ==== rtl/acf_device.sv ====
/*
 Drive end: opcode decode, monitoring records, link power, security.
 Assumes media logic answers media_ack / media_committed on aclk.
*/
// The address map and the AXI4-Lite register port are this design's own decisions.
// Contract
// - Opcode write last, starts execution
// - Forced-unit-access writes finish after commit
// - Verify reads internally, returns no data
// - Trusted opcodes only in encrypting builds
// - Opcode B0h returns monitoring data
// - Decode all monitoring subcommand codes
// - Attribute record byte layout, raw LSB first
// - Six required attributes reported
// - Active state: link fully up
// - Partial resumes under 10 us
// - Slumber resumes under 10 ms
// - Auto-slumber moves partial to slumber
// - Host or device may request low power
// - Sleep pin forces deepest sleep
// - Sleep powers link down; host bounds
// - Sleep exit within 20 ms
// - Count block reads, refresh at threshold
// - Path error reported before media write
// - Locked until correct password
// - Range access needs the range key
// - One 256-bit key both directions
// - Host writes staged to single-bit cells
`timescale 1ns/1ps
`include "acf_defines.svh"
module acf_device
   import acf_pkg::*;
#(
   parameter int SLUMBER_CYC = `ACF_SLUMBER_MS * 1000 * `ACF_CLK_MHZ,
   parameter int DEVSLP_EXIT_CYC = `ACF_DEVSLP_EXIT_MS * 1000 * `ACF_CLK_MHZ
)(
   input wire logic aclk,
   input wire logic aresetn,
   acf_if.dev bus,
   input wire logic se_fitted,
   input wire logic auto_slumber_en,
   input wire logic dipm_en,
   input wire logic [31:0] password,
   input wire logic [31:0] range_key,
   input wire logic [255:0] cipher_key,
   input wire logic [15:0] init_bad,
   input wire logic [15:0] later_bad,
   input wire logic [15:0] max_erase,
   input wire logic [15:0] avg_erase,
   input wire logic [15:0] on_hours,
   input wire logic [15:0] pwr_cycles,
   input wire logic media_ack,
   input wire logic [31:0] media_rdata,
   input wire logic media_committed,
   output logic media_we,
   output logic media_re,
   output logic media_slc,
   output logic [15:0] media_addr,
   output logic [31:0] media_wdata,
   output logic refresh_req,
   output logic [2:0] refresh_blk,
   output logic link_off
);
   localparam int PARTIAL_CYC = `ACF_PARTIAL_US * `ACF_CLK_MHZ;

   typedef struct packed {
      acf_pwr_t pst;
      acf_cst_t cst;
      logic [7:0] op;
      logic [7:0] feat;
      logic [15:0] lba;
      logic [31:0] wd;
      logic [31:0] key;
      logic perr;
      logic [19:0] tmr;
      logic [11:0] idle;
      logic [1:0] slp;
      logic busy;
      logic done;
      logic err;
      logic rdv;
      logic [31:0] rdd;
      logic dpm;
      logic lock;
      logic sm_en;
      logic asave;
      logic thr;
      logic [2:0] ai;
      logic [3:0] bi;
      logic [7:0][7:0] rcnt;
      logic rf;
      logic [2:0] rfb;
      logic mwe;
      logic mre;
      logic slc;
      logic rdir;
      logic [15:0] maddr;
      logic [31:0] mwd;
      logic off;
   } acf_dev_st_t;

   acf_dev_st_t q;
   acf_dev_st_t n;
   logic [31:0] kx [9];
   logic [7:0] rcn;

   // Key folded to the data width; same fold both ways keeps it symmetric
   assign kx[0] = '0;
   genvar g;
   for (g = 0; g < 8; g++)
   begin : g_fold
      assign kx[g + 1] = kx[g] ^ cipher_key[g * 32 +: 32];
   end

   function automatic acf_cls_t decode(input logic [7:0] op, input logic sef);
      case (op)
         `ACF_OPS_MISC: decode = ACF_C_MISC;
         `ACF_OP_UNLOCK: decode = ACF_C_UNLK;
         `ACF_OPS_WR: decode = ACF_C_WR;
         `ACF_OP_FUA_DMA, `ACF_OP_FUA_MUL: decode = ACF_C_FUA;
         `ACF_OPS_RD: decode = ACF_C_RD;
         `ACF_OP_VFY, `ACF_OP_VFY_EXT: decode = ACF_C_VFY;
         `ACF_OPS_TRUST: decode = sef ? ACF_C_TRUST : ACF_C_BAD;
         `ACF_OP_SMART: decode = ACF_C_SMART;
         default: decode = ACF_C_BAD;
      endcase
   endfunction

   function automatic logic [7:0] rec_byte(input logic [2:0] ai, input logic [3:0] bi,
      input logic thr, input logic [15:0] raw);
      logic [7:0] id;
      logic [15:0] fl;
      fl = `ACF_ATTR_FLAGS;
      case (ai)
         3'h0: id = `ACF_ID_INIT_BAD;
         3'h1: id = `ACF_ID_LATER_BAD;
         3'h2: id = `ACF_ID_MAX_ERASE;
         3'h3: id = `ACF_ID_AVG_ERASE;
         3'h4: id = `ACF_ID_PON_HOURS;
         default: id = `ACF_ID_PWR_CYC;
      endcase
      case (bi)
         4'h0: rec_byte = id;
         4'h1: rec_byte = thr ? `ACF_ATTR_THR : fl[7:0];
         4'h2: rec_byte = thr ? 8'h00 : fl[15:8];
         4'h3, 4'h4: rec_byte = thr ? 8'h00 : `ACF_ATTR_VALUE;
         4'h5: rec_byte = thr ? 8'h00 : raw[7:0];
         4'h6: rec_byte = thr ? 8'h00 : raw[15:8];
         default: rec_byte = 8'h00;
      endcase
   endfunction

   always_comb
   begin
      acf_cls_t cls;
      logic bad_acc;
      logic [95:0] raws;
      cls = decode(q.op, se_fitted);
      bad_acc = (se_fitted && q.lock) || (q.lba[15] && q.key != range_key);
      raws = {pwr_cycles, on_hours, avg_erase, max_erase, later_bad, init_bad};
      rcn = q.rcnt[q.lba[2:0]] + 8'h01;
      n = q;
      n.done = 1'b0;
      n.rdv = 1'b0;
      n.dpm = 1'b0;
      n.rf = 1'b0;
      n.mwe = 1'b0;
      n.mre = 1'b0;
      n.slp = {q.slp[0], bus.devslp};
      n.idle = q.busy ? '0 : (q.idle == `ACF_IDLE_CYC ? q.idle : q.idle + 12'h001);
      case (q.pst)
         ACF_ACTIVE:
         begin
            if (q.slp[1])
               n.pst = ACF_DEVSLP;
            else if (!q.busy && !bus.cmd_we && bus.pm_req != `ACF_PM_NONE)
            begin
               n.pst = (bus.pm_req == `ACF_PM_SLUMBER) ? ACF_SLUMBER : ACF_PARTIAL;
               n.idle = '0;
            end
            else if (!q.busy && !bus.cmd_we && dipm_en && q.idle == `ACF_IDLE_CYC)
            begin
               n.dpm = 1'b1;
               n.pst = ACF_PARTIAL;
               n.idle = '0;
            end
         end
         ACF_PARTIAL:
         begin
            if (q.slp[1])
               n.pst = ACF_DEVSLP;
            else if (bus.wake)
            begin
               n.pst = ACF_WAKE;
               n.tmr = 20'(PARTIAL_CYC - 2);
            end
            else if (auto_slumber_en && q.idle == `ACF_IDLE_CYC)
               n.pst = ACF_SLUMBER;
         end
         ACF_SLUMBER:
         begin
            if (q.slp[1])
               n.pst = ACF_DEVSLP;
            else if (bus.wake)
            begin
               n.pst = ACF_WAKE;
               n.tmr = 20'(SLUMBER_CYC - 2);
            end
         end
         ACF_DEVSLP:
         begin
            if (!q.slp[1])
            begin
               n.pst = ACF_WAKE;
               n.tmr = 20'(DEVSLP_EXIT_CYC - 2);
            end
         end
         ACF_WAKE:
         begin
            if (q.slp[1])
               n.pst = ACF_DEVSLP;
            else if (q.tmr == '0)
               n.pst = ACF_ACTIVE;
            else
               n.tmr = q.tmr - 20'h0_0001;
         end
         default: n.pst = ACF_ACTIVE;
      endcase
      n.off = (n.pst == ACF_DEVSLP);
      case (q.cst)
         ACF_IDLE:
         begin
            if (bus.cmd_we)
            begin
               n.op = bus.op;
               n.feat = bus.feat;
               n.lba = bus.lba;
               n.wd = bus.wd;
               n.key = bus.key;
               n.perr = (^bus.wd) != bus.wpar;
               n.busy = q.pst == ACF_ACTIVE;
               n.cst = (q.pst == ACF_ACTIVE) ? ACF_EXEC : ACF_IDLE;
               n.done = q.pst != ACF_ACTIVE;
               n.err = q.pst != ACF_ACTIVE;
            end
         end
         ACF_EXEC:
         begin
            n.cst = ACF_IDLE;
            n.busy = 1'b0;
            n.done = 1'b1;
            n.err = 1'b0;
            case (cls)
               ACF_C_BAD: n.err = 1'b1;
               ACF_C_UNLK:
               begin
                  n.err = se_fitted && q.key != password;
                  n.lock = q.lock && n.err;
               end
               ACF_C_WR, ACF_C_FUA:
               begin
                  if (bad_acc || q.perr)
                     n.err = 1'b1;
                  else
                  begin
                     n.mwe = 1'b1;
                     n.slc = 1'b1;
                     n.maddr = q.lba;
                     n.mwd = q.wd ^ kx[8];
                     if (cls == ACF_C_FUA)
                     begin
                        n.cst = ACF_COMMIT;
                        n.busy = 1'b1;
                        n.done = 1'b0;
                     end
                  end
               end
               ACF_C_RD, ACF_C_VFY:
               begin
                  if (bad_acc)
                     n.err = 1'b1;
                  else
                  begin
                     n.mre = 1'b1;
                     n.maddr = q.lba;
                     n.rdir = cls == ACF_C_RD;
                     n.cst = ACF_MEDIA;
                     n.busy = 1'b1;
                     n.done = 1'b0;
                  end
               end
               ACF_C_SMART:
               begin
                  if (q.feat != `ACF_SM_EN && !q.sm_en)
                     n.err = 1'b1;
                  else
                     case (q.feat)
                        `ACF_SM_EN: n.sm_en = 1'b1;
                        `ACF_SM_DIS: n.sm_en = 1'b0;
                        `ACF_SM_ASAVE: n.asave = q.lba[0];
                        `ACF_SM_OFFL, `ACF_SM_RLOG, `ACF_SM_WLOG: n.err = 1'b0;
                        `ACF_SM_STAT:
                        begin
                           n.rdv = 1'b1;
                           n.rdd = `ACF_SMART_OK;
                        end
                        `ACF_SM_RDATA, `ACF_SM_RTHR:
                        begin
                           n.thr = q.feat == `ACF_SM_RTHR;
                           n.ai = '0;
                           n.bi = '0;
                           n.rdv = 1'b1;
                           n.rdd = {24'h00_0000, rec_byte(3'h0, 4'h0, n.thr, raws[15:0])};
                           n.cst = ACF_SMART;
                           n.busy = 1'b1;
                           n.done = 1'b0;
                        end
                        default: n.err = 1'b1;
                     endcase
               end
               default: n.err = 1'b0;
            endcase
         end
         ACF_MEDIA:
         begin
            if (media_ack)
            begin
               n.rdv = q.rdir;
               n.rdd = q.rdir ? media_rdata ^ kx[8] : q.rdd;
               n.rf = rcn == `ACF_READ_THRESH;
               n.rfb = q.lba[2:0];
               n.rcnt[q.lba[2:0]] = n.rf ? 8'h00 : rcn;
               n.cst = ACF_IDLE;
               n.busy = 1'b0;
               n.done = 1'b1;
            end
         end
         ACF_COMMIT:
         begin
            if (media_committed)
            begin
               n.cst = ACF_IDLE;
               n.busy = 1'b0;
               n.done = 1'b1;
            end
         end
         ACF_SMART:
         begin
            if (bus.rack)
            begin
               if (q.ai == `ACF_ATTR_NUM && q.bi == `ACF_REC_LAST)
               begin
                  n.cst = ACF_IDLE;
                  n.busy = 1'b0;
                  n.done = 1'b1;
               end
               else
               begin
                  n.ai = (q.bi == `ACF_REC_LAST) ? q.ai + 3'h1 : q.ai;
                  n.bi = (q.bi == `ACF_REC_LAST) ? 4'h0 : q.bi + 4'h1;
                  n.rdv = 1'b1;
                  n.rdd = {24'h00_0000, rec_byte(n.ai, n.bi, q.thr, raws[n.ai * 16 +: 16])};
               end
            end
         end
         default: n.cst = ACF_IDLE;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         q <= '0;
         q.lock <= 1'b1;
      end
      else
         q <= n;
   end

   assign bus.busy = q.busy;
   assign bus.done = q.done;
   assign bus.err = q.err;
   assign bus.rdv = q.rdv;
   assign bus.rdd = q.rdd;
   assign bus.pwr = q.pst;
   assign bus.dev_pm = q.dpm;
   assign media_we = q.mwe;
   assign media_re = q.mre;
   assign media_slc = q.slc;
   assign media_addr = q.maddr;
   assign media_wdata = q.mwd;
   assign refresh_req = q.rf;
   assign refresh_blk = q.rfb;
   assign link_off = q.off;
endmodule // acf_device

// ==== rtl/acf_host.sv ====
/*
 Host end: AXI4-Lite register slave driving the link.
 Assumes software writes parameters before the command register.
*/
`timescale 1ns/1ps
`include "acf_defines.svh"
module acf_host
   import acf_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   acf_if.host bus,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   typedef struct packed {
      logic awr, wr, bv, arr, rv;
      logic awh, wh;
      logic [7:0] awa;
      logic [31:0] wdt;
      logic [1:0] br, rr;
      logic [31:0] rdt;
      logic cwe;
      logic [7:0] op, feat;
      logic [15:0] lba;
      logic [31:0] wd, key, rdat;
      logic rack, wake, slp;
      logic [1:0] pm;
      logic done_s, err_s, rdv_s, dpm_s;
   } acf_host_st_t;

   acf_host_st_t q;
   acf_host_st_t n;

   always_comb
   begin
      logic wr_go;
      logic [31:0] clr;
      wr_go = q.awh && q.wh && !q.bv;
      clr = (wr_go && q.awa == `ACF_REG_STAT) ? q.wdt : '0;
      n = q;
      n.cwe = 1'b0;
      n.rack = 1'b0;
      n.wake = 1'b0;
      n.pm = `ACF_PM_NONE;
      // Set wins over a clear in the same cycle
      n.done_s = bus.done || (q.done_s && !clr[1]);
      n.err_s = (bus.done && bus.err) || (q.err_s && !clr[2]);
      n.rdv_s = bus.rdv || (q.rdv_s && !clr[3]);
      n.dpm_s = bus.dev_pm || (q.dpm_s && !clr[7]);
      n.rdat = bus.rdv ? bus.rdd : q.rdat;
      if (s_axi_awvalid && q.awr)
      begin
         n.awh = 1'b1;
         n.awa = s_axi_awaddr;
      end
      if (s_axi_wvalid && q.wr)
      begin
         n.wh = 1'b1;
         n.wdt = s_axi_wdata;
      end
      n.awr = !n.awh && !q.bv;
      n.wr = !n.wh && !q.bv;
      if (wr_go)
      begin
         n.awh = 1'b0;
         n.wh = 1'b0;
         n.bv = 1'b1;
         n.br = `ACF_RESP_OK;
         case (q.awa)
            `ACF_REG_CMD:
            begin
               n.op = q.wdt[7:0];
               n.feat = q.wdt[15:8];
               n.cwe = 1'b1;
            end
            `ACF_REG_LBA: n.lba = q.wdt[15:0];
            `ACF_REG_DATA: n.wd = q.wdt;
            `ACF_REG_KEY: n.key = q.wdt;
            `ACF_REG_PM:
            begin
               n.pm = q.wdt[1:0];
               n.wake = q.wdt[2];
               n.slp = q.wdt[3];
            end
            `ACF_REG_STAT: n.br = `ACF_RESP_OK;
            default: n.br = `ACF_RESP_ERR;
         endcase
      end
      else if (q.bv && s_axi_bready)
         n.bv = 1'b0;
      if (s_axi_arvalid && q.arr)
      begin
         n.arr = 1'b0;
         n.rv = 1'b1;
         n.rr = `ACF_RESP_OK;
         case (s_axi_araddr)
            `ACF_REG_CMD: n.rdt = {16'h0000, q.feat, q.op};
            `ACF_REG_LBA: n.rdt = {16'h0000, q.lba};
            `ACF_REG_DATA: n.rdt = q.wd;
            `ACF_REG_KEY: n.rdt = q.key;
            `ACF_REG_PM: n.rdt = {28'h000_0000, q.slp, 3'h0};
            `ACF_REG_STAT: n.rdt = {24'h00_0000, q.dpm_s, bus.pwr, q.rdv_s, q.err_s, q.done_s,
               bus.busy};
            `ACF_REG_RDATA:
            begin
               n.rdt = q.rdat;
               n.rack = q.rdv_s;
               n.rdv_s = bus.rdv;
            end
            default:
            begin
               n.rdt = '0;
               n.rr = `ACF_RESP_ERR;
            end
         endcase
      end
      else if (q.rv && s_axi_rready)
      begin
         n.rv = 1'b0;
         n.arr = 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         q <= '0;
         q.awr <= 1'b1;
         q.wr <= 1'b1;
         q.arr <= 1'b1;
      end
      else
         q <= n;
   end

   assign s_axi_awready = q.awr;
   assign s_axi_wready = q.wr;
   assign s_axi_bvalid = q.bv;
   assign s_axi_bresp = q.br;
   assign s_axi_arready = q.arr;
   assign s_axi_rvalid = q.rv;
   assign s_axi_rdata = q.rdt;
   assign s_axi_rresp = q.rr;
   assign bus.cmd_we = q.cwe;
   assign bus.op = q.op;
   assign bus.feat = q.feat;
   assign bus.lba = q.lba;
   assign bus.wd = q.wd;
   assign bus.wpar = ^q.wd;
   assign bus.key = q.key;
   assign bus.rack = q.rack;
   assign bus.pm_req = q.pm;
   assign bus.wake = q.wake;
   assign bus.devslp = q.slp;
endmodule // acf_host

// ==== test/acf_link_sva.sv ====
/* Link checker.
 Assumes sim-sized power counts. */
`timescale 1ns/1ps
module acf_link_sva
   import acf_pkg::*;
#(
   parameter int SLUMBER_CYC = 20,
   parameter int DEVSLP_EXIT_CYC = 20
)(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic cmd_we,
   input wire logic [31:0] wd,
   input wire logic wpar,
   input wire logic [1:0] pm_req,
   input wire logic wake,
   input wire logic devslp,
   input wire logic busy,
   input wire logic done,
   input wire logic err,
   input wire acf_pwr_t pwr
);
   localparam int SLW = SLUMBER_CYC + 1;
   localparam int EXW = DEVSLP_EXIT_CYC + 4;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_par_even: assert property (wpar == ^wd)
      else $error("bad parity");
   chk_busy_cause: assert property ($rose(busy) |-> $past(cmd_we))
      else $error("busy without opcode");
   chk_lowpwr_err: assert property (cmd_we && !busy && pwr != ACF_ACTIVE |=> done && err)
      else $error("command not refused");
   chk_part_wake: assert property (pwr == ACF_PARTIAL && wake |-> ##[1:251] pwr == ACF_ACTIVE)
      else $error("partial wake late");
   chk_slum_wake: assert property (pwr == ACF_SLUMBER && wake |-> ##[1:SLW] pwr == ACF_ACTIVE)
      else $error("slumber wake late");
   chk_pm_enter: assert property (pm_req == 2'h1 && pwr == ACF_ACTIVE && !busy && !cmd_we
      |=> pwr == ACF_PARTIAL)
      else $error("partial not entered");
   chk_slp_enter: assert property ($rose(devslp) |-> ##[1:4] pwr == ACF_DEVSLP)
      else $error("sleep not entered");
   chk_slp_exit: assert property ($fell(devslp) && pwr == ACF_DEVSLP
      |-> ##[1:EXW] pwr == ACF_ACTIVE)
      else $error("sleep exit late");
   cov_cmd_ok: cover property (done && !err);
   cov_slumber: cover property (pwr == ACF_SLUMBER);
   cov_sleep: cover property (pwr == ACF_DEVSLP);
endmodule // acf_link_sva

// ==== test/ata_command_power_front_end_bench.sv ====
/* Host and drive ends joined by the link.
 Assumes media answers one cycle after each request. */
`timescale 1ns/1ps
`include "acf_defines.svh"
module ata_command_power_front_end_bench;
   import acf_pkg::*;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000, rdata, s;
   logic awready, wready, bvalid, arready, rvalid, media_we, media_re, media_slc;
   logic [1:0] bresp, rresp, r;
   logic se = 0, auto_sl = 0, ack = 0, cmt = 0, dipm = 0;
   logic [15:0] raws [6] = '{16'h1234, 16'h0002, 16'h0A0B, 16'h0506, 16'h7788, 16'h0099};
   logic [7:0] ids [6] = '{8'hA5, 8'hA6, 8'hA3, 8'hA4, 8'h09, 8'h0C};
   logic [7:0] subs [7] = '{8'hD8, 8'hD9, 8'hD8, 8'hD2, 8'hD4, 8'hD5, 8'hD6};
   logic [7:0] eb;
   int n_errors = 0, tests_run = 0, cyc = 0;
   acf_if lnk();
   acf_host i_acf_host (.aclk(aclk), .aresetn(aresetn), .bus(lnk), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   acf_device #(.SLUMBER_CYC(20), .DEVSLP_EXIT_CYC(20)) i_acf_device (.aclk(aclk),
      .aresetn(aresetn), .bus(lnk), .se_fitted(se), .auto_slumber_en(auto_sl),
      .dipm_en(dipm), .password(32'h5A5A_1234), .range_key(32'h0000_0077),
      .cipher_key({8{32'h5A5A_1234}}), .init_bad(raws[0]), .later_bad(raws[1]),
      .max_erase(raws[2]), .avg_erase(raws[3]), .on_hours(raws[4]), .pwr_cycles(raws[5]),
      .media_ack(ack), .media_rdata(32'h0000_0000), .media_committed(cmt),
      .media_we(media_we), .media_re(media_re), .media_slc(media_slc), .media_addr(),
      .media_wdata(), .refresh_req(), .refresh_blk(), .link_off());
   acf_link_sva #(.SLUMBER_CYC(20), .DEVSLP_EXIT_CYC(20)) i_acf_link_sva (.aclk(aclk),
      .aresetn(aresetn), .cmd_we(lnk.cmd_we), .wd(lnk.wd), .wpar(lnk.wpar),
      .pm_req(lnk.pm_req), .wake(lnk.wake), .devslp(lnk.devslp), .busy(lnk.busy),
      .done(lnk.done), .err(lnk.err), .pwr(lnk.pwr));
   always #20 aclk = ~aclk;
   always @(posedge aclk)
   begin
      ack <= media_re;
      cmt <= media_we;
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_errors++;
         tally_and_finish();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e)
      begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do
      begin
         @(posedge aclk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (!bvalid);
      r = bresp;
      bready <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do
      begin
         @(posedge aclk);
         if (arready) arvalid <= 1'h0;
      end while (!rvalid);
      s = rdata;
      r = rresp;
      rready <= 1'h0;
   endtask
   task automatic cmd(input logic [7:0] op, input logic [1:0] e, input logic [7:0] ft = 8'h00,
      input logic [15:0] lba = 16'h0000);
      wr(`ACF_REG_LBA, {16'h0000, lba});
      wr(`ACF_REG_CMD, {16'h0000, ft, op});
      do rd(`ACF_REG_STAT); while (s[1] !== 1'h1);
      chk("rdv_err", e, s[3:2]);
      wr(`ACF_REG_STAT, 32'h0000_008E);
   endtask
   task automatic pw(input logic [2:0] e);
      rd(`ACF_REG_STAT);
      for (int k = 0; k < 100 && s[6:4] !== e; k++) rd(`ACF_REG_STAT);
      chk("pwr", e, s[6:4]);
   endtask
   task automatic pm(input logic [3:0] v, input logic [2:0] e);
      wr(`ACF_REG_PM, {28'h000_0000, v});
      pw(e);
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'h1;
      rd(`ACF_REG_STAT);
      chk("status", 32'h0000_0000, s);
      rd(8'hFC);
      chk("rresp", `ACF_RESP_ERR, r);
      wr(8'hFC, 32'h0000_0001);
      chk("bresp", `ACF_RESP_ERR, r);
      $display("map test done");
      cmd(8'h3D, 2'h0);
      cmd(8'hCE, 2'h0);
      chk("slc", 1'h1, media_slc);
      cmd(8'h40, 2'h0);
      cmd(8'h42, 2'h0);
      cmd(8'h20, 2'h2);
      cmd(8'h5C, 2'h1);
      cmd(8'hFF, 2'h1);
      cmd(8'hB0, 2'h1, 8'hC0);
      foreach (subs[i]) cmd(8'hB0, 2'h0, subs[i]);
      cmd(8'hB0, 2'h2, 8'hDA);
      rd(`ACF_REG_RDATA);
      chk("smart_ok", `ACF_SMART_OK, s);
      se <= 1'h1;
      cmd(8'h20, 2'h1);
      wr(`ACF_REG_KEY, 32'h5A5A_1234);
      cmd(8'hF2, 2'h0);
      cmd(8'h20, 2'h1, 8'h00, 16'h8000);
      wr(`ACF_REG_KEY, 32'h0000_0077);
      cmd(8'h20, 2'h2, 8'h00, 16'h8000);
      cmd(8'h5C, 2'h0);
      $display("command test done");
      wr(`ACF_REG_CMD, 32'h0000_D0B0);
      for (int i = 0; i < 72; i++)
      begin
         eb = (i % 12 == 0) ? ids[i / 12] : (i % 12 == 1) ? 8'h03 : 8'h00;
         if (i % 12 == 3 || i % 12 == 4) eb = 8'h64;
         if (i % 12 == 5) eb = raws[i / 12][7:0];
         if (i % 12 == 6) eb = raws[i / 12][15:8];
         do rd(`ACF_REG_STAT); while (s[3] !== 1'h1);
         rd(`ACF_REG_RDATA);
         chk("attr_byte", eb, s[7:0]);
      end
      // Stale done from the record read would satisfy the next command poll
      wr(`ACF_REG_STAT, 32'h0000_008E);
      $display("attribute test done");
      pm(4'h1, ACF_PARTIAL);
      cmd(8'hE5, 2'h1);
      pm(4'h4, ACF_ACTIVE);
      pm(4'h2, ACF_SLUMBER);
      pm(4'h4, ACF_ACTIVE);
      auto_sl <= 1'h1;
      wr(`ACF_REG_PM, 32'h0000_0001);
      repeat (2100) @(posedge aclk);
      pw(ACF_SLUMBER);
      pm(4'h4, ACF_ACTIVE);
      pm(4'h8, ACF_DEVSLP);
      pm(4'h0, ACF_ACTIVE);
      dipm <= 1'h1;
      pw(ACF_PARTIAL);
      rd(`ACF_REG_STAT);
      chk("dev_pm", 1'h1, s[7]);
      $display("power test done");
      tally_and_finish();
   end
endmodule // ata_command_power_front_end_bench
